// >>> hw/psd_pkg.sv
`default_nettype none
package psd_pkg;
  // strap vector bit positions
  localparam int STRAP_N = 8;
  localparam int SI_P1_MFC = 0;
  localparam int SI_P2_XAUTO = 1;
  localparam int SI_P2_XMAN = 2;
  localparam int SI_P2_AN = 3;
  localparam int SI_P2_SPD = 4;
  localparam int SI_P2_DUP = 5;
  localparam int SI_P2_BP = 6;
  localparam int SI_P2_FDFC = 7;
  // default strap levels, bit per index above
  localparam logic [STRAP_N-1:0] STRAP_DEFAULT = 8'hfa;
  // software write selectors
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] REG_HWCFG = 3'h0;
  localparam logic [SEL_W-1:0] REG_P1_MFC = 3'h1;
  localparam logic [SEL_W-1:0] REG_P1_ADV = 3'h2;
  localparam logic [SEL_W-1:0] REG_P2_BASIC = 3'h3;
  localparam logic [SEL_W-1:0] REG_P2_ADV = 3'h4;
  localparam logic [SEL_W-1:0] REG_P2_MODES = 3'h5;
  localparam logic [SEL_W-1:0] REG_P2_MFC = 3'h6;
  localparam logic [SEL_W-1:0] REG_P2_XCTL = 3'h7;
  localparam int DATA_W = 8;
  // field positions inside the write data
  localparam int B_HW_XAUTO = 0;
  localparam int B_ADV_10HD = 0;
  localparam int B_ADV_10FD = 1;
  localparam int B_ADV_SYM = 2;
  localparam int B_ADV_ASYM = 3;
  localparam int B_BC_AN = 0;
  localparam int B_BC_SPD = 1;
  localparam int B_BC_DUP = 2;
  localparam int B_FC_SEL = 0;
  localparam int B_FC_BP = 1;
  localparam int B_FC_TX = 2;
  localparam int B_FC_RX = 3;
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_ALL = 3'h7;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h7;
  localparam logic P2_MFC_SEL_DEFAULT = 1'b0;
  // crossover control and resulting mode
  localparam logic [1:0] XC_STRAP = 2'h0;
  localparam logic [1:0] XC_AUTO = 2'h1;
  localparam logic [1:0] XC_MDI = 2'h2;
  localparam logic [1:0] XC_MDIX = 2'h3;
  localparam logic [1:0] XM_MDI = 2'h0;
  localparam logic [1:0] XM_MDIX = 2'h1;
  localparam logic [1:0] XM_AUTO = 2'h2;
  typedef enum logic [2:0] {
    PSD_CAPTURE = 3'b001,
    PSD_LOAD = 3'b010,
    PSD_RUN = 3'b100
  } psd_state_t;
endpackage
`default_nettype wire

// >>> hw/psd_port_strap_defaults.sv
`default_nettype none
module psd_port_strap_defaults
  import psd_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic p1_manual_flowctl_strap,
  input wire logic p2_crossover_led_pin,
  input wire logic p2_manual_crossover_strap,
  input wire logic p2_autoneg_strap,
  input wire logic p2_speed_strap,
  input wire logic p2_duplex_strap,
  input wire logic p2_backpressure_strap,
  input wire logic p2_fullduplex_flowctl_strap,
  input wire logic sw_wr_en,
  input wire logic [SEL_W-1:0] sw_wr_sel,
  input wire logic [DATA_W-1:0] sw_wr_data,
  output logic defaults_loaded,
  output logic auto_crossover_strap_state,
  output logic p1_manual_flowctl_select,
  output logic p1_adv_sym_pause,
  output logic p1_adv_asym_pause,
  output logic autonegotiation_enable,
  output logic speed_select_low_bit,
  output logic duplex_bit,
  output logic p2_adv_10t_half,
  output logic p2_adv_10t_full,
  output logic p2_adv_sym_pause,
  output logic p2_adv_asym_pause,
  output logic [MODE_W-1:0] p2_phy_mode,
  output logic p2_manual_flowctl_select,
  output logic p2_backpressure_enable,
  output logic p2_tx_flowctl_enable,
  output logic p2_rx_flowctl_enable,
  output logic [1:0] auto_crossover_control,
  output logic [1:0] p2_crossover_mode
);

  if (SYNC_STAGES < 2) begin : g_sync_check
    $error("SYNC_STAGES must be at least 2");
  end

  logic [STRAP_N-1:0] strap_pins;
  logic [STRAP_N-1:0] sync_q [SYNC_STAGES];
  logic [STRAP_N-1:0] strap_latch;
  psd_state_t state;
  psd_state_t next_state;
  logic next_loaded;
  logic next_xauto;
  logic next_p1_sel;
  logic next_p1_sym;
  logic next_p1_asym;
  logic next_an;
  logic next_spd;
  logic next_dup;
  logic next_10hd;
  logic next_10fd;
  logic next_p2_sym;
  logic next_p2_asym;
  logic [MODE_W-1:0] next_mode;
  logic next_p2_sel;
  logic next_bp;
  logic next_tx;
  logic next_rx;
  logic [1:0] next_xctl;
  logic [1:0] next_xmode;

  assign strap_pins = {p2_fullduplex_flowctl_strap, p2_backpressure_strap,
                       p2_duplex_strap, p2_speed_strap, p2_autoneg_strap,
                       p2_manual_crossover_strap, p2_crossover_led_pin,
                       p1_manual_flowctl_strap};

  // synchroniser runs through reset so straps are settled at release
  always_ff @(posedge clk) begin
    sync_q[0] <= strap_pins;
    for (int i = 1; i < SYNC_STAGES; i++) begin
      sync_q[i] <= sync_q[i-1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_latch <= sync_q[SYNC_STAGES-1];
    end
  end

  always_comb begin
    next_state = state;
    next_loaded = defaults_loaded;
    next_xauto = auto_crossover_strap_state;
    next_p1_sel = p1_manual_flowctl_select;
    next_p1_sym = p1_adv_sym_pause;
    next_p1_asym = p1_adv_asym_pause;
    next_an = autonegotiation_enable;
    next_spd = speed_select_low_bit;
    next_dup = duplex_bit;
    next_10hd = p2_adv_10t_half;
    next_10fd = p2_adv_10t_full;
    next_p2_sym = p2_adv_sym_pause;
    next_p2_asym = p2_adv_asym_pause;
    next_mode = p2_phy_mode;
    next_p2_sel = p2_manual_flowctl_select;
    next_bp = p2_backpressure_enable;
    next_tx = p2_tx_flowctl_enable;
    next_rx = p2_rx_flowctl_enable;
    next_xctl = auto_crossover_control;
    case (state)
      PSD_CAPTURE: next_state = PSD_LOAD;
      PSD_LOAD: begin
        next_state = PSD_RUN;
        next_loaded = 1'b1;
        next_p1_sel = strap_latch[SI_P1_MFC];
        next_p1_sym = strap_latch[SI_P1_MFC];
        next_p1_asym = strap_latch[SI_P1_MFC];
        next_xauto = strap_latch[SI_P2_XAUTO];
        next_an = strap_latch[SI_P2_AN];
        next_spd = strap_latch[SI_P2_SPD];
        next_dup = strap_latch[SI_P2_DUP];
        if (strap_latch[SI_P2_AN]) begin
          next_10hd = 1'b1;
          next_10fd = strap_latch[SI_P2_DUP];
          next_mode = MODE_ALL;
        end else begin
          // forced mode advertises only the strapped 10t ability
          next_10hd = ~strap_latch[SI_P2_SPD] & ~strap_latch[SI_P2_DUP];
          next_10fd = ~strap_latch[SI_P2_SPD] & strap_latch[SI_P2_DUP];
          next_mode = {1'b0, strap_latch[SI_P2_SPD], strap_latch[SI_P2_DUP]};
        end
        next_bp = strap_latch[SI_P2_BP];
        next_tx = strap_latch[SI_P2_FDFC];
        next_rx = strap_latch[SI_P2_FDFC];
        next_p2_asym = strap_latch[SI_P2_FDFC];
        next_p2_sym = strap_latch[SI_P2_FDFC];
      end
      PSD_RUN: begin
        if (sw_wr_en) begin
          case (sw_wr_sel)
            REG_HWCFG: next_xauto = sw_wr_data[B_HW_XAUTO];
            REG_P1_MFC: next_p1_sel = sw_wr_data[B_FC_SEL];
            REG_P1_ADV: begin
              next_p1_sym = sw_wr_data[B_ADV_SYM];
              next_p1_asym = sw_wr_data[B_ADV_ASYM];
            end
            REG_P2_BASIC: begin
              next_an = sw_wr_data[B_BC_AN];
              next_spd = sw_wr_data[B_BC_SPD];
              next_dup = sw_wr_data[B_BC_DUP];
            end
            REG_P2_ADV: begin
              next_10hd = sw_wr_data[B_ADV_10HD];
              next_10fd = sw_wr_data[B_ADV_10FD];
              next_p2_sym = sw_wr_data[B_ADV_SYM];
              next_p2_asym = sw_wr_data[B_ADV_ASYM];
            end
            REG_P2_MODES: next_mode = sw_wr_data[MODE_W-1:0];
            REG_P2_MFC: begin
              next_p2_sel = sw_wr_data[B_FC_SEL];
              next_bp = sw_wr_data[B_FC_BP];
              next_tx = sw_wr_data[B_FC_TX];
              next_rx = sw_wr_data[B_FC_RX];
            end
            REG_P2_XCTL: next_xctl = sw_wr_data[1:0];
            default: next_xctl = auto_crossover_control;
          endcase
        end
      end
      default: next_state = PSD_LOAD;
    endcase
  end

  // crossover resolves from the registered state, one cycle behind
  always_comb begin
    next_xmode = XM_AUTO;
    case (auto_crossover_control)
      XC_STRAP: begin
        if (auto_crossover_strap_state) begin
          next_xmode = XM_AUTO;
        end else if (strap_latch[SI_P2_XMAN]) begin
          next_xmode = XM_MDIX;
        end else begin
          next_xmode = XM_MDI;
        end
      end
      XC_AUTO: next_xmode = XM_AUTO;
      XC_MDI: next_xmode = XM_MDI;
      XC_MDIX: next_xmode = XM_MDIX;
      default: next_xmode = XM_AUTO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= PSD_CAPTURE;
      defaults_loaded <= 1'b0;
      auto_crossover_strap_state <= STRAP_DEFAULT[SI_P2_XAUTO];
      p1_manual_flowctl_select <= STRAP_DEFAULT[SI_P1_MFC];
      p1_adv_sym_pause <= STRAP_DEFAULT[SI_P1_MFC];
      p1_adv_asym_pause <= STRAP_DEFAULT[SI_P1_MFC];
      autonegotiation_enable <= STRAP_DEFAULT[SI_P2_AN];
      speed_select_low_bit <= STRAP_DEFAULT[SI_P2_SPD];
      duplex_bit <= STRAP_DEFAULT[SI_P2_DUP];
      p2_adv_10t_half <= 1'b1;
      p2_adv_10t_full <= STRAP_DEFAULT[SI_P2_DUP];
      p2_adv_sym_pause <= STRAP_DEFAULT[SI_P2_FDFC];
      p2_adv_asym_pause <= STRAP_DEFAULT[SI_P2_FDFC];
      p2_phy_mode <= MODE_RESET;
      p2_manual_flowctl_select <= P2_MFC_SEL_DEFAULT;
      p2_backpressure_enable <= STRAP_DEFAULT[SI_P2_BP];
      p2_tx_flowctl_enable <= STRAP_DEFAULT[SI_P2_FDFC];
      p2_rx_flowctl_enable <= STRAP_DEFAULT[SI_P2_FDFC];
      auto_crossover_control <= XC_STRAP;
      p2_crossover_mode <= XM_AUTO;
    end else begin
      state <= next_state;
      defaults_loaded <= next_loaded;
      auto_crossover_strap_state <= next_xauto;
      p1_manual_flowctl_select <= next_p1_sel;
      p1_adv_sym_pause <= next_p1_sym;
      p1_adv_asym_pause <= next_p1_asym;
      autonegotiation_enable <= next_an;
      speed_select_low_bit <= next_spd;
      duplex_bit <= next_dup;
      p2_adv_10t_half <= next_10hd;
      p2_adv_10t_full <= next_10fd;
      p2_adv_sym_pause <= next_p2_sym;
      p2_adv_asym_pause <= next_p2_asym;
      p2_phy_mode <= next_mode;
      p2_manual_flowctl_select <= next_p2_sel;
      p2_backpressure_enable <= next_bp;
      p2_tx_flowctl_enable <= next_tx;
      p2_rx_flowctl_enable <= next_rx;
      auto_crossover_control <= next_xctl;
      p2_crossover_mode <= next_xmode;
    end
  end

  default clocking cb @(posedge clk); endclocking

  sequence s_load_run;
    state == PSD_LOAD ##1 state == PSD_RUN && defaults_loaded;
  endsequence

  sequence s_p2_mfc_write;
    state == PSD_RUN && sw_wr_en && sw_wr_sel == REG_P2_MFC;
  endsequence

  p1_select_load_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> p1_manual_flowctl_select == $past(strap_latch[0]))
    else $error("p1 select not loaded from strap");
  p1_pause_adv_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> p1_adv_sym_pause == $past(strap_latch[0])
      && p1_adv_asym_pause == $past(strap_latch[0]))
    else $error("p1 pause advertisement wrong");
  xover_state_load_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> auto_crossover_strap_state == $past(strap_latch[1]))
    else $error("crossover strap state wrong");
  xover_auto_a: assert property (disable iff (!rst_n)
    auto_crossover_control == XC_STRAP && auto_crossover_strap_state
      |=> p2_crossover_mode == XM_AUTO)
    else $error("strap auto crossover not applied");
  xover_manual_a: assert property (disable iff (!rst_n)
    auto_crossover_control == XC_STRAP && !auto_crossover_strap_state
      |=> p2_crossover_mode == ($past(strap_latch[2]) ? XM_MDIX : XM_MDI))
    else $error("manual crossover strap not applied");
  an_enable_load_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> autonegotiation_enable == $past(strap_latch[3]))
    else $error("autoneg enable not loaded");
  an_mode_all_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD && strap_latch[3]
      |=> p2_phy_mode == MODE_ALL && p2_adv_10t_half)
    else $error("autoneg strap mode wrong");
  speed_load_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD && !strap_latch[3]
      |=> speed_select_low_bit == $past(strap_latch[4])
      && p2_phy_mode[1] == $past(strap_latch[4])
      && (p2_adv_10t_half | p2_adv_10t_full) == !$past(strap_latch[4]))
    else $error("speed strap effects wrong");
  duplex_load_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> duplex_bit == $past(strap_latch[5])
      && (!p2_adv_10t_full || $past(strap_latch[SI_P2_DUP])))
    else $error("duplex strap effects wrong");
  bp_load_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> p2_backpressure_enable == $past(strap_latch[6]))
    else $error("backpressure enable not loaded");
  fd_fc_load_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> p2_tx_flowctl_enable == $past(strap_latch[7])
      && p2_rx_flowctl_enable == $past(strap_latch[7]))
    else $error("fd flow-control enables wrong");
  asym_pause_a: assert property (disable iff (!rst_n)
    state == PSD_LOAD |=> p2_adv_asym_pause == $past(strap_latch[7]))
    else $error("p2 asym pause wrong");
  strap_capture_a: assert property (
    (!rst_n) [*3] |=> strap_latch == $past(sync_q[SYNC_STAGES-1]))
    else $error("straps not captured in reset");
  load_sequence_a: assert property (disable iff (!rst_n)
    state == PSD_CAPTURE |=> s_load_run)
    else $error("load sequence broken");
  sw_write_a: assert property (disable iff (!rst_n)
    s_p2_mfc_write |=> p2_backpressure_enable == $past(sw_wr_data[1])
      && p2_tx_flowctl_enable == $past(sw_wr_data[2]))
    else $error("software write to p2 flow control lost");

endmodule
`default_nettype wire

// >>> tb/psd_strap_board.sv
`default_nettype none
module psd_strap_board
  import psd_pkg::*;
(
  input wire logic clk,
  input wire logic led_act,
  input wire logic [STRAP_N-1:0] lvl,
  output logic [STRAP_N-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic blink;
  // led pin is a live output once running, so it must not look static
  always_ff @(posedge clk) begin
    blink <= led_act ? ~blink : 1'b0;
  end
  always_comb begin
    pin = lvl;
    pin[SI_P2_XAUTO] = lvl[SI_P2_XAUTO] ^ (led_act & blink);
  end
endmodule
`default_nettype wire

// >>> tb/psd_port_strap_defaults_tb_top.sv
`default_nettype none
module psd_port_strap_defaults_tb_top
  import psd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [STRAP_N-1:0] s;
    logic [MODE_W-1:0] m;
    logic [1:0] x;
  } psd_row_t;
  localparam logic [22:0] M_X = 23'h7c000f;
  localparam logic [22:0] M_A = 23'h03ff00;
  localparam logic [22:0] M_F = 23'h0000f0;
  localparam logic [22:0] RST_V = {1'b0, 1'b1, 3'h0, 7'h7f, MODE_RESET,
    1'b0, 1'b1, 2'h3, XC_STRAP, XM_AUTO};
  logic clk, rst_n, led_act, sw_wr_en;
  logic [STRAP_N-1:0] lvl;
  logic [SEL_W-1:0] sw_wr_sel;
  logic [DATA_W-1:0] sw_wr_data;
  wire logic [STRAP_N-1:0] pin;
  logic ld, xs, p1s, p1y, p1a, an, spd, dup, h10, f10, sy, as;
  logic p2s, bp, tx, rx;
  logic [MODE_W-1:0] mode;
  logic [1:0] xc, xm;
  logic [22:0] got, exp_v;
  int bad_count, checked, i, k;
  // one row per strap pattern: levels, expected mode, expected crossover
  psd_row_t rows [6] = '{'{8'hfa, 3'h7, XM_AUTO}, '{8'h05, 3'h0, XM_MDIX},
    '{8'h31, 3'h3, XM_MDI}, '{8'h60, 3'h1, XM_MDI},
    '{8'h98, 3'h7, XM_MDI}, '{8'h52, 3'h2, XM_AUTO}};
  logic [1:0] xexp [4] = '{XM_AUTO, XM_AUTO, XM_MDI, XM_MDIX};
  assign got = {ld, xs, p1s, p1y, p1a, an, spd, dup, h10, f10, sy, as,
    mode, p2s, bp, tx, rx, xc, xm};

  psd_strap_board brd (.clk(clk), .led_act(led_act), .lvl(lvl), .pin(pin));
  psd_port_strap_defaults uut (
    .clk(clk), .rst_n(rst_n),
    .p1_manual_flowctl_strap(pin[SI_P1_MFC]),
    .p2_crossover_led_pin(pin[SI_P2_XAUTO]),
    .p2_manual_crossover_strap(pin[SI_P2_XMAN]),
    .p2_autoneg_strap(pin[SI_P2_AN]), .p2_speed_strap(pin[SI_P2_SPD]),
    .p2_duplex_strap(pin[SI_P2_DUP]),
    .p2_backpressure_strap(pin[SI_P2_BP]),
    .p2_fullduplex_flowctl_strap(pin[SI_P2_FDFC]),
    .sw_wr_en(sw_wr_en), .sw_wr_sel(sw_wr_sel), .sw_wr_data(sw_wr_data),
    .defaults_loaded(ld), .auto_crossover_strap_state(xs),
    .p1_manual_flowctl_select(p1s), .p1_adv_sym_pause(p1y),
    .p1_adv_asym_pause(p1a), .autonegotiation_enable(an),
    .speed_select_low_bit(spd), .duplex_bit(dup), .p2_adv_10t_half(h10),
    .p2_adv_10t_full(f10), .p2_adv_sym_pause(sy), .p2_adv_asym_pause(as),
    .p2_phy_mode(mode), .p2_manual_flowctl_select(p2s),
    .p2_backpressure_enable(bp), .p2_tx_flowctl_enable(tx),
    .p2_rx_flowctl_enable(rx), .auto_crossover_control(xc),
    .p2_crossover_mode(xm));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [22:0] exp_of(psd_row_t r);
    logic [STRAP_N-1:0] s;
    logic h, f;
    s = r.s;
    h = s[SI_P2_AN] | (~s[SI_P2_SPD] & ~s[SI_P2_DUP]);
    f = s[SI_P2_AN] ? s[SI_P2_DUP] : (~s[SI_P2_SPD] & s[SI_P2_DUP]);
    return {1'b1, s[SI_P2_XAUTO], {3{s[SI_P1_MFC]}}, s[SI_P2_AN],
      s[SI_P2_SPD], s[SI_P2_DUP], h, f, {2{s[SI_P2_FDFC]}}, r.m,
      P2_MFC_SEL_DEFAULT, s[SI_P2_BP], {2{s[SI_P2_FDFC]}}, XC_STRAP, r.x};
  endfunction

  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp(input logic [22:0] g, input logic [22:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t outputs %h expected %h", $time, g, e);
    end
  endtask

  // hold reset past the synchroniser depth so the straps are latched
  task automatic do_reset(input logic [STRAP_N-1:0] s);
    @(negedge clk);
    rst_n = 1'b0;
    led_act = 1'b0;
    lvl = s;
    repeat (4) @(negedge clk);
    cmp(got, RST_V);
    rst_n = 1'b1;
    led_act = 1'b1;
  endtask

  task automatic wait_load();
    k = 0;
    while (ld !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    if (ld !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t defaults never loaded", $time);
      print_verdict();
    end
    @(negedge clk);
  endtask

  // leaves the strobe high so back to back writes need no gap
  task automatic wr(input logic [SEL_W-1:0] sel, input logic [7:0] d);
    sw_wr_en = 1'b1;
    sw_wr_sel = sel;
    sw_wr_data = d;
    @(negedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    led_act = 1'b0;
    lvl = STRAP_DEFAULT;
    sw_wr_en = 1'b0;
    sw_wr_sel = '0;
    sw_wr_data = '0;
    bad_count = 0;
    checked = 0;
    for (i = 0; i < 6; i++) begin
      do_reset(rows[i].s);
      wait_load();
      exp_v = exp_of(rows[i]);
      cmp(got & M_X, exp_v & M_X);
      cmp(got & M_A, exp_v & M_A);
      cmp(got & M_F, exp_v & M_F);
      lvl = ~rows[i].s;
      repeat (4) @(negedge clk);
      cmp(got, exp_v);
    end
    // writes held through capture and load must be dropped
    do_reset(STRAP_DEFAULT);
    wr(REG_P2_MFC, 8'h00);
    wr(REG_P2_MFC, 8'h00);
    sw_wr_en = 1'b0;
    @(negedge clk);
    wait_load();
    exp_v = exp_of(rows[0]);
    cmp(got, exp_v);
    for (i = 0; i < 4; i++) begin
      wr(REG_P2_XCTL, 8'(i));
      @(negedge clk);
      exp_v[3:0] = {2'(i), xexp[i]};
      cmp(got, exp_v);
    end
    wr(REG_P2_MFC, 8'h00);
    wr(REG_P2_BASIC, 8'h00);
    sw_wr_en = 1'b0;
    @(negedge clk);
    exp_v[7:4] = 4'h0;
    exp_v[17:15] = 3'h0;
    cmp(got, exp_v);
    wr(REG_P2_MFC, 8'h0f);
    wr(REG_P1_MFC, 8'h01);
    wr(REG_P1_ADV, 8'h0c);
    wr(REG_P2_ADV, 8'h03);
    wr(REG_P2_MODES, 8'h05);
    wr(REG_HWCFG, 8'h00);
    sw_wr_en = 1'b0;
    @(negedge clk);
    exp_v[7:4] = 4'hf;
    exp_v[21:18] = 4'h7;
    exp_v[14:8] = 7'h65;
    cmp(got, exp_v);
    // cleared strap state with strap control falls back to manual strap
    wr(REG_P2_XCTL, {6'h00, XC_STRAP});
    sw_wr_en = 1'b0;
    @(negedge clk);
    exp_v[3:0] = {XC_STRAP, XM_MDI};
    cmp(got, exp_v);
    print_verdict();
  end
endmodule
`default_nettype wire
